//--- hw/vmfm_comp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "vmfm_regs.svh"

module vmfm_comp_ctrl
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control link
	vmfm_ctrl_if.comp ctrl
);

	vmfm_pkg::vmfm_pd_state_t state_q;
	vmfm_pkg::vmfm_pd_state_t state_d;
	logic enablePrev_q;
	logic enablePrev_d;

	always_comb
	begin
		state_d = state_q;
		enablePrev_d = ctrl.enableLevel;
		case (state_q)
			vmfm_pkg::VMFM_COMP_ON:
			begin
				if (ctrl.powerDownEnable && !ctrl.enableLevel && ctrl.recordDone)
				begin
					state_d = vmfm_pkg::VMFM_COMP_OFF; // RL1
				end
			end
			vmfm_pkg::VMFM_COMP_OFF:
			begin
				// bit cleared while off: off comparators must run again
				if ((ctrl.enableLevel && !enablePrev_q) || !ctrl.powerDownEnable)
				begin
					state_d = vmfm_pkg::VMFM_COMP_ON; // RL2 RL3
				end
			end
			default:
			begin
				state_d = vmfm_pkg::VMFM_COMP_ON;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= vmfm_pkg::VMFM_COMP_ON;
			enablePrev_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			enablePrev_q <= enablePrev_d;
		end
	end

	assign ctrl.compOff = (state_q == vmfm_pkg::VMFM_COMP_OFF);
	// off comparators only drop out in power-down
	assign ctrl.offCompEnable = ctrl.compOff ? `VMFM_ZERO_CHAN : `VMFM_ALL_CHAN; // RL3
	assign ctrl.ovCompEnable = ctrl.compOff ? `VMFM_ZERO_CHAN : ctrl.monEnable; // RL4
	assign ctrl.uvCompEnable = ctrl.compOff ? `VMFM_ZERO_CHAN : ctrl.monEnable; // RL4

endmodule

`default_nettype wire

//--- hw/vmfm_fault_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "vmfm_regs.svh"

module vmfm_fault_map
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// stored configuration
	input wire logic [7:0] otpMonEnable,
	input wire logic [7:0] otpResetMap,
	input wire logic otpReload,
	// register port from the serial management interface
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// pins and analog comparator outputs
	input wire logic primaryEnableInput,
	input wire logic [6:0] ovCompIn,
	input wire logic [6:0] uvCompIn,
	// internal status
	input wire logic parityFault,
	input wire logic recordDone,
	// comparator control
	output logic [6:0] ovCompEnable,
	output logic [6:0] uvCompEnable,
	output logic [6:0] offCompEnable,
	output logic comparatorsOff,
	// reset output
	output logic resetFaultFlag,
	output logic resetOut_n
);

	vmfm_ctrl_if ctrl();

	vmfm_comp_ctrl u_comp
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.ctrl(ctrl)
	);

	// synchronisers for the enable pin and comparator outputs from outside the clock domain
	logic enMeta_q;
	logic enSync_q;
	vmfm_pkg::vmfm_chan_t ovMeta_q;
	vmfm_pkg::vmfm_chan_t ovSync_q;
	vmfm_pkg::vmfm_chan_t uvMeta_q;
	vmfm_pkg::vmfm_chan_t uvSync_q;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			enMeta_q <= 1'b0;
			enSync_q <= 1'b0;
			ovMeta_q <= `VMFM_ZERO_CHAN;
			ovSync_q <= `VMFM_ZERO_CHAN;
			uvMeta_q <= `VMFM_ZERO_CHAN;
			uvSync_q <= `VMFM_ZERO_CHAN;
		end
		else
		begin
			enMeta_q <= primaryEnableInput;
			enSync_q <= enMeta_q;
			ovMeta_q <= ovCompIn;
			ovSync_q <= ovMeta_q;
			uvMeta_q <= uvCompIn;
			uvSync_q <= uvMeta_q;
		end
	end

	// register state
	logic loadPending_q;
	logic loadPending_d;
	logic [7:0] monEnableReg_q;
	logic [7:0] monEnableReg_d;
	logic [7:0] resetMapReg_q;
	logic [7:0] resetMapReg_d;
	vmfm_pkg::vmfm_chan_t ovStatus_q;
	vmfm_pkg::vmfm_chan_t ovStatus_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic faultFlag_q;
	logic faultFlag_d;
	logic resetOut_n_q;
	logic resetOut_n_d;

	vmfm_pkg::vmfm_chan_t ovEvent;
	vmfm_pkg::vmfm_chan_t uvEvent;
	logic statusRead;

	function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
		addrHit = (addr == target);
	endfunction

	assign ctrl.monEnable = monEnableReg_q[`VMFM_CHAN_MSB:`VMFM_CHAN_LSB]; // RL4
	assign ctrl.powerDownEnable = monEnableReg_q[`VMFM_BIT_POWER_DOWN]; // RL1
	assign ctrl.enableLevel = enSync_q;
	assign ctrl.recordDone = recordDone;

	// a channel only faults while its comparator is powered
	assign ovEvent = ovSync_q & ctrl.ovCompEnable;
	assign uvEvent = uvSync_q & ctrl.uvCompEnable;
	assign statusRead = regRead && addrHit(regAddr, `VMFM_ADDR_OV_STATUS);

	always_comb
	begin
		loadPending_d = 1'b0;
		monEnableReg_d = monEnableReg_q;
		resetMapReg_d = resetMapReg_q;
		// configuration is caught after reset release, never under reset
		if (loadPending_q || otpReload)
		begin
			monEnableReg_d = otpMonEnable; // RL10
			resetMapReg_d = otpResetMap; // RL10
		end
		else if (regWrite)
		begin
			if (addrHit(regAddr, `VMFM_ADDR_MON_ENABLE))
			begin
				monEnableReg_d = regWdata;
			end
			if (addrHit(regAddr, `VMFM_ADDR_RESET_MAP))
			begin
				resetMapReg_d = regWdata;
			end
		end
	end

	always_comb
	begin
		ovStatus_d = ovStatus_q;
		if (statusRead)
		begin
			ovStatus_d = `VMFM_ZERO_CHAN; // RL8
		end
		// new overvoltage wins over a simultaneous read clear
		ovStatus_d = ovStatus_d | ovEvent; // RL7 RL9
	end

	always_comb
	begin
		rdata_d = rdata_q;
		if (regRead)
		begin
			if (addrHit(regAddr, `VMFM_ADDR_MON_ENABLE))
			begin
				rdata_d = monEnableReg_q;
			end
			else if (addrHit(regAddr, `VMFM_ADDR_RESET_MAP))
			begin
				rdata_d = resetMapReg_q;
			end
			else if (addrHit(regAddr, `VMFM_ADDR_OV_STATUS))
			begin
				rdata_d = {1'b0, ovStatus_q}; // RL8
			end
			else
			begin
				rdata_d = `VMFM_ZERO_BYTE;
			end
		end
	end

	always_comb
	begin
		faultFlag_d = (|(resetMapReg_q[`VMFM_CHAN_MSB:`VMFM_CHAN_LSB] & (ovEvent | uvEvent))) // RL6
			|| (resetMapReg_q[`VMFM_BIT_PARITY_MAP] && parityFault); // RL5
		resetOut_n_d = !faultFlag_q; // RL11
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			loadPending_q <= 1'b1;
			monEnableReg_q <= `VMFM_ZERO_BYTE;
			resetMapReg_q <= `VMFM_ZERO_BYTE;
			ovStatus_q <= `VMFM_ZERO_CHAN;
			rdata_q <= `VMFM_ZERO_BYTE;
			faultFlag_q <= 1'b0;
			resetOut_n_q <= 1'b0;
		end
		else
		begin
			loadPending_q <= loadPending_d;
			monEnableReg_q <= monEnableReg_d;
			resetMapReg_q <= resetMapReg_d;
			ovStatus_q <= ovStatus_d;
			rdata_q <= rdata_d;
			faultFlag_q <= faultFlag_d;
			resetOut_n_q <= resetOut_n_d;
		end
	end

	assign regRdata = rdata_q;
	assign ovCompEnable = ctrl.ovCompEnable;
	assign uvCompEnable = ctrl.uvCompEnable;
	assign offCompEnable = ctrl.offCompEnable;
	assign comparatorsOff = ctrl.compOff;
	assign resetFaultFlag = faultFlag_q;
	assign resetOut_n = resetOut_n_q;

endmodule

`default_nettype wire

//--- inc/vmfm_ctrl_if.sv
`timescale 1ns/10ps
`default_nettype none

interface vmfm_ctrl_if;
	vmfm_pkg::vmfm_chan_t monEnable;
	logic powerDownEnable;
	logic enableLevel;
	logic recordDone;
	logic compOff;
	vmfm_pkg::vmfm_chan_t ovCompEnable;
	vmfm_pkg::vmfm_chan_t uvCompEnable;
	vmfm_pkg::vmfm_chan_t offCompEnable;

	modport regs
	(
		output monEnable,
		output powerDownEnable,
		output enableLevel,
		output recordDone,
		input compOff,
		input ovCompEnable,
		input uvCompEnable,
		input offCompEnable
	);

	modport comp
	(
		input monEnable,
		input powerDownEnable,
		input enableLevel,
		input recordDone,
		output compOff,
		output ovCompEnable,
		output uvCompEnable,
		output offCompEnable
	);
endinterface

`default_nettype wire

//--- inc/vmfm_pkg.sv
package vmfm_pkg;

	typedef logic [6:0] vmfm_chan_t;

	typedef enum logic [1:0]
	{
		VMFM_COMP_ON = 2'b01,
		VMFM_COMP_OFF = 2'b10
	} vmfm_pd_state_t;

endpackage

//--- inc/vmfm_regs.svh
// Contract
// RL1 - power-down bit, enable low, recording done: comparators off
// RL2 - rising enable edge turns comparators back on
// RL3 - power-down clear: off comparators always enabled
// RL4 - enable bits 6..0 gate channels 7..1 monitors
// RL5 - map bit 7 routes parity faults to reset
// RL6 - map bits 6..0 route channel faults to reset
// RL7 - status bits 6..0 flag channel overvoltage
// RL8 - reading status returns it, then clears all
// RL9 - status bits latch until read
// RL10 - enable and map reset from stored configuration
// RL11 - reset-fault flag drives inverted reset pin
`ifndef VMFM_REGS_SVH
`define VMFM_REGS_SVH

`define VMFM_ADDR_MON_ENABLE 8'h03
`define VMFM_ADDR_RESET_MAP 8'h04
`define VMFM_ADDR_OV_STATUS 8'h05

`define VMFM_BIT_POWER_DOWN 7
`define VMFM_BIT_PARITY_MAP 7
`define VMFM_CHAN_MSB 6
`define VMFM_CHAN_LSB 0

`define VMFM_ZERO_BYTE 8'h00
`define VMFM_ZERO_CHAN 7'h00
`define VMFM_ALL_CHAN 7'h7F

`endif

//--- sim/vmfm_fault_map_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module vmfm_fault_map_monitor
(
	// watched ports
	input wire logic sys_clk, rst, regRead, regWrite, otpReload, primaryEnableInput, recordDone,
	input wire logic comparatorsOff, resetFaultFlag, resetOut_n,
	input wire logic [7:0] regAddr, regRdata, regWdata,
	input wire logic [6:0] ovCompEnable, uvCompEnable, offCompEnable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence stRd;
		regRead && regAddr == 8'h05;
	endsequence
	unmapped_read_a: assert property (regRead && !(regAddr inside {[8'h03:8'h05]}) |=> regRdata == 8'h00)
		else $error("unmapped read");
	status_msb_a: assert property (stRd |=> !regRdata[7])
		else $error("status msb");
	pin_inverse_a: assert property ($changed(resetFaultFlag) |=> resetOut_n == !$past(resetFaultFlag))
		else $error("reset pin");
	power_off_a: assert property (comparatorsOff |-> (ovCompEnable | uvCompEnable | offCompEnable) == 7'h00)
		else $error("enables while off");
	off_kept_a: assert property (!comparatorsOff |-> offCompEnable == 7'h7F)
		else $error("off comparators");
	ovuv_pair_a: assert property (ovCompEnable == uvCompEnable)
		else $error("ov uv differ");
	off_entry_a: assert property ($rose(comparatorsOff) |-> $past(recordDone) && !$past(primaryEnableInput, 3))
		else $error("power down");
	off_exit_a: assert property ($fell(comparatorsOff) |-> ($past(primaryEnableInput, 3) && !$past(primaryEnableInput, 4))
		|| $past(regWrite && regAddr == 8'h03 && !regWdata[7], 2) || $past(otpReload, 2))
		else $error("power up");
endmodule
bind vmfm_fault_map vmfm_fault_map_monitor mon (.*);
`default_nettype wire

//--- sim/vmfm_fault_map_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; $display("FAIL %0t %h %h", $time, a, b); end end
module vmfm_fault_map_test;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic otpReload = 1'h0;
	logic [7:0] otpMonEnable, otpResetMap, regAddr, regWdata, regRdata, d, m, r;
	logic regWrite, regRead, primaryEnableInput, parityFault, recordDone, resetFaultFlag, resetOut_n, comparatorsOff;
	logic [6:0] ovCompIn, uvCompIn, ovCompEnable, uvCompEnable, offCompEnable;
	int errorCnt, checked, cyc, seed = 86;
	always #25 sys_clk = ~sys_clk;
	vmfm_host_model host (.*);
	vmfm_fault_map dut (.*);
	function automatic logic flagExp(input logic [7:0] mn, mp, input logic [6:0] o, u, input logic p);
		return (|(mp[6:0] & mn[6:0] & (o | u))) | (mp[7] & p);
	endfunction
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errorCnt++;
			give_verdict();
		end
	end
	initial
	begin
		otpMonEnable = 8'($random(seed));
		otpResetMap = 8'($random(seed));
		{primaryEnableInput, parityFault, recordDone, ovCompIn, uvCompIn} = 17'h1_0000;
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (3) @(posedge sys_clk);
		host.rd(8'h03, d);
		`CHK(d, otpMonEnable)
		host.rd(8'h04, d);
		`CHK(d, otpResetMap)
		host.rd(8'h09, d);
		`CHK(d, 8'h00)
		$display("reset test done");
		for (int i = 0; i < 24; i++)
		begin
			m = i ? 8'($random(seed)) : 8'h7F;
			r = i ? 8'($random(seed)) : 8'h80;
			host.wr(8'h03, m);
			host.wr(8'h04, r);
			@(posedge sys_clk);
			ovCompIn <= 7'($random(seed));
			uvCompIn <= 7'($random(seed));
			parityFault <= 1'($random(seed));
			repeat (5) @(posedge sys_clk);
			#1;
			`CHK(ovCompEnable, m[6:0])
			`CHK(uvCompEnable, m[6:0])
			`CHK(resetFaultFlag, flagExp(m, r, ovCompIn, uvCompIn, parityFault))
			`CHK(resetOut_n, ~flagExp(m, r, ovCompIn, uvCompIn, parityFault))
			host.rd(8'h04, d);
			`CHK(d, r)
		end
		$display("fault test done");
		@(posedge sys_clk);
		{ovCompIn, uvCompIn, parityFault} <= 15'h0000;
		host.wr(8'h03, 8'h7F);
		repeat (3) @(posedge sys_clk);
		host.rd(8'h05, d);
		m = (8'($random(seed)) | 8'h41) & 8'h7F;
		@(posedge sys_clk);
		ovCompIn <= m[6:0];
		@(posedge sys_clk);
		ovCompIn <= 7'h00;
		repeat (4) @(posedge sys_clk);
		host.rd(8'h05, d);
		`CHK(d, m)
		host.rd(8'h05, d);
		`CHK(d, 8'h00)
		$display("status test done");
		host.wr(8'h03, m | 8'h80);
		@(posedge sys_clk);
		{primaryEnableInput, recordDone} <= 2'h1;
		repeat (5) @(posedge sys_clk);
		#1;
		`CHK({comparatorsOff, offCompEnable, ovCompEnable}, 15'h4000)
		`CHK(uvCompEnable, 7'h00)
		@(posedge sys_clk);
		{primaryEnableInput, recordDone} <= 2'h2;
		repeat (5) @(posedge sys_clk);
		#1;
		`CHK({comparatorsOff, offCompEnable, ovCompEnable}, {8'h7F, m[6:0]})
		@(posedge sys_clk);
		{primaryEnableInput, recordDone} <= 2'h1;
		repeat (5) @(posedge sys_clk);
		#1;
		`CHK(comparatorsOff, 1'h1)
		host.wr(8'h03, m);
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK({comparatorsOff, offCompEnable}, 8'h7F)
		$display("power test done");
		@(posedge sys_clk);
		otpMonEnable <= 8'($random(seed));
		otpResetMap <= 8'($random(seed));
		otpReload <= 1'h1;
		@(posedge sys_clk);
		otpReload <= 1'h0;
		host.rd(8'h03, d);
		`CHK(d, otpMonEnable)
		host.rd(8'h04, d);
		`CHK(d, otpResetMap)
		$display("reload test done");
		give_verdict();
	end
endmodule
`default_nettype wire

//--- sim/vmfm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module vmfm_host_model
(
	// register port
	input wire logic sys_clk,
	input wire logic [7:0] regRdata,
	output logic [7:0] regAddr,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regWdata
);
	initial
	begin
		{regAddr, regWrite, regRead, regWdata} = 18'h0_0000;
	end
	// released lines show inverted data so a stale value cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		{regAddr, regWdata, regWrite} <= {a, v, 1'h1};
		@(posedge sys_clk);
		{regAddr, regWdata, regWrite} <= {~a, ~v, 1'h0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		{regAddr, regRead} <= {a, 1'h1};
		@(posedge sys_clk);
		{regAddr, regRead} <= {~a, 1'h0};
		#1 v = regRdata;
	endtask
endmodule
`default_nettype wire
